// >>> inc/eac_pkg.sv
// Constants, field layout and timing of the nonvolatile memory access control block
// *****************************************************************************
// *****************************************************************************
package eac_pkg;

  // *****************************************************************************
  // Register offsets and field positions
  // *****************************************************************************
  localparam logic [5:0] EAC_OFS_CONTROL   = 6'h1C;
  localparam logic [5:0] EAC_OFS_DATA      = 6'h1D;
  localparam logic [5:0] EAC_OFS_ADDR_LOW  = 6'h1E;
  localparam logic [5:0] EAC_OFS_ADDR_HIGH = 6'h1F;

  localparam int EAC_BIT_READ_STROBE = 0;
  localparam int EAC_BIT_PROG_ENABLE = 1;
  localparam int EAC_BIT_MASTER      = 2;
  localparam int EAC_BIT_RDY_IRQ_EN  = 3;
  localparam int EAC_BIT_MODE_LO     = 4;
  localparam int EAC_BIT_MODE_HI     = 5;

  localparam logic [1:0] EAC_MODE_ATOMIC   = 2'h0;
  localparam logic [1:0] EAC_MODE_ERASE    = 2'h1;
  localparam logic [1:0] EAC_MODE_WRITE    = 2'h2;
  localparam logic [1:0] EAC_MODE_RESERVED = 2'h3;

  localparam logic [1:0] EAC_MODE_RESET = 2'h0;
  localparam logic [7:0] EAC_DATA_RESET = 8'h00;

  // Set for the 512-byte variant, which owns the top address bit
  localparam logic EAC_HAS_TOP_BIT = 1'b0;

  // *****************************************************************************
  // Timing
  // *****************************************************************************
  localparam logic [2:0] EAC_MASTER_WINDOW = 3'h4;
  localparam logic [2:0] EAC_PROG_STALL    = 3'h2;
  localparam logic [2:0] EAC_READ_STALL    = 3'h4;

  // Programming times in microseconds, oscillator rate in kHz
  localparam int EAC_ATOMIC_TIME_US = 3400;
  localparam int EAC_SPLIT_TIME_US  = 1800;
  localparam int EAC_OSC_FREQ_KHZ   = 8000;
  localparam int EAC_ATOMIC_TICKS   = (EAC_ATOMIC_TIME_US * EAC_OSC_FREQ_KHZ + 999) / 1000;
  localparam int EAC_SPLIT_TICKS    = (EAC_SPLIT_TIME_US * EAC_OSC_FREQ_KHZ + 999) / 1000;

  typedef enum logic {
    EAC_IDLE,
    EAC_BUSY
  } eac_state_type;

endpackage : eac_pkg

// >>> rtl/eac_sync_edge.sv
// Two-flop synchroniser with rising-edge pulse for the oscillator input
`timescale 1ns/100ps
`default_nettype none
module eac_sync_edge (
  input  wire logic clk,
  input  wire logic async_in,
  output logic      rise
);

  logic meta;
  logic stable;
  logic stable_d;

  // Free running so that timing survives a reset during programming
  always_ff @(posedge clk) begin
    meta     <= async_in;
    stable   <= meta;
    stable_d <= stable;
    rise     <= stable & ~stable_d;
  end

endmodule : eac_sync_edge
`default_nettype wire

// >>> rtl/eac_prog_timer.sv
// Down counter of oscillator ticks timing one programming operation
`timescale 1ns/100ps
`default_nettype none
module eac_prog_timer (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        start,
  input  wire logic [15:0] ticks,
  input  wire logic        tick,
  output logic             done
);

  logic [15:0] remaining;
  logic        running;

  // A running count ignores reset so the operation completes
  always_ff @(posedge clk) begin
    if (!resetn && !running) begin
      remaining <= 16'h0000;
      done      <= 1'b0;
    end else if (start) begin
      remaining <= ticks;
      done      <= 1'b0;
    end else if (running && tick) begin
      remaining <= remaining - 16'h0001;
      done      <= (remaining == 16'h0001);
    end else begin
      done      <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn && !running) begin
      running <= 1'b0;
    end else if (start) begin
      running <= 1'b1;
    end else if (running && tick && remaining == 16'h0001) begin
      running <= 1'b0;
    end
  end

endmodule : eac_prog_timer
`default_nettype wire

// >>> rtl/eac_core.sv
// Register file, sequencing and CPU stall for the byte-wide nonvolatile memory
`timescale 1ns/100ps
`default_nettype none
module eac_core #(
  parameter int ATOMIC_TICKS = eac_pkg::EAC_ATOMIC_TICKS,
  parameter int SPLIT_TICKS  = eac_pkg::EAC_SPLIT_TICKS
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [5:0] io_addr,
  input  wire logic [7:0] io_wdata,
  input  wire logic       io_write,
  input  wire logic       io_read,
  output logic      [7:0] io_rdata,
  input  wire logic       global_irq_enable,
  input  wire logic       osc_clk,
  output logic      [8:0] mem_addr,
  output logic      [7:0] mem_wdata,
  output logic            mem_read,
  output logic            mem_erase,
  output logic            mem_program,
  input  wire logic [7:0] mem_rdata,
  output logic            cpu_stall,
  output logic            ready_irq
);

  // *****************************************************************************
  // Decode
  // *****************************************************************************
  function automatic logic hit(input logic [5:0] ofs);
    hit = io_write && (io_addr == ofs);
  endfunction : hit

  eac_pkg::eac_state_type state;

  logic [1:0] prog_mode_field;
  logic       ready_irq_enable;
  logic       master_prog_enable;
  logic [2:0] master_count;
  logic       prog_enable;
  logic [7:0] nvm_data;
  logic [8:0] nvm_address;
  logic [2:0] stall_count;
  logic       read_pending;
  logic       busy;
  logic       osc_tick;
  logic       prog_done;
  logic       ctrl_write;
  logic       want_prog;
  logic       want_read;
  logic       start_prog;
  logic       start_read;
  logic [1:0] next_mode;
  logic [15:0] next_ticks;

  assign busy       = (state == eac_pkg::EAC_BUSY);
  assign ctrl_write = hit(eac_pkg::EAC_OFS_CONTROL);
  assign want_prog  = ctrl_write && io_wdata[eac_pkg::EAC_BIT_PROG_ENABLE];
  assign want_read  = ctrl_write && io_wdata[eac_pkg::EAC_BIT_READ_STROBE];

  // Mode in force for a start issued by this same write
  assign next_mode = io_wdata[eac_pkg::EAC_BIT_MODE_HI:eac_pkg::EAC_BIT_MODE_LO];

  // Reserved mode starts no programming operation
  assign start_prog = want_prog && master_prog_enable && !busy
                      && (next_mode != eac_pkg::EAC_MODE_RESERVED) && resetn;
  assign start_read = want_read && !busy && !start_prog && resetn;

  always_comb begin
    next_ticks = 16'(SPLIT_TICKS);
    if (next_mode == eac_pkg::EAC_MODE_ATOMIC) begin
      next_ticks = 16'(ATOMIC_TICKS);
    end
  end

  // *****************************************************************************
  // Oscillator timebase
  // *****************************************************************************
  eac_sync_edge u_osc_sync (
    .clk      (clk),
    .async_in (osc_clk),
    .rise     (osc_tick)
  );

  eac_prog_timer u_prog_timer (
    .clk    (clk),
    .resetn (resetn),
    .start  (start_prog),
    .ticks  (next_ticks),
    .tick   (osc_tick),
    .done   (prog_done)
  );

  // *****************************************************************************
  // Programming sequence
  // *****************************************************************************
  always_ff @(posedge clk) begin
    if (!resetn && !busy) begin
      state <= eac_pkg::EAC_IDLE;
    end else begin
      case (state)
        eac_pkg::EAC_IDLE: begin
          if (start_prog) begin
            state <= eac_pkg::EAC_BUSY;
          end
        end
        eac_pkg::EAC_BUSY: begin
          if (prog_done) begin
            state <= eac_pkg::EAC_IDLE;
          end
        end
        default: begin
          state <= eac_pkg::EAC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn && !busy) begin
      prog_enable <= 1'b0;
    end else if (start_prog) begin
      prog_enable <= 1'b1;
    end else if (busy && prog_done) begin
      prog_enable <= 1'b0;
    end
  end

  // Array strobes are held for the whole operation
  always_ff @(posedge clk) begin
    if (!resetn && !busy) begin
      mem_erase   <= 1'b0;
      mem_program <= 1'b0;
    end else if (start_prog) begin
      mem_erase   <= (next_mode != eac_pkg::EAC_MODE_WRITE);
      // Write-only never erases, so an unerased target byte ends up undefined
      mem_program <= (next_mode != eac_pkg::EAC_MODE_ERASE);
    end else if (busy && prog_done) begin
      mem_erase   <= 1'b0;
      mem_program <= 1'b0;
    end
  end

  // *****************************************************************************
  // Control register fields
  // *****************************************************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      if (!busy) begin
        prog_mode_field <= eac_pkg::EAC_MODE_RESET;
      end
    end else if (ctrl_write && !prog_enable) begin
      prog_mode_field <= next_mode;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ready_irq_enable <= 1'b0;
    end else if (ctrl_write) begin
      ready_irq_enable <= io_wdata[eac_pkg::EAC_BIT_RDY_IRQ_EN];
    end
  end

  // Master enable lives four cycles after the setting write
  always_ff @(posedge clk) begin
    if (!resetn) begin
      master_prog_enable <= 1'b0;
      master_count       <= 3'h0;
    end else if (ctrl_write && io_wdata[eac_pkg::EAC_BIT_MASTER]) begin
      master_prog_enable <= 1'b1;
      master_count       <= eac_pkg::EAC_MASTER_WINDOW;
    end else if (start_prog) begin
      master_prog_enable <= 1'b0;
      master_count       <= 3'h0;
    end else if (master_count != 3'h0) begin
      master_count       <= master_count - 3'h1;
      master_prog_enable <= (master_count != 3'h1);
    end
  end

  // *****************************************************************************
  // Address and data registers
  // *****************************************************************************
  always_ff @(posedge clk) begin
    if (!busy) begin
      if (hit(eac_pkg::EAC_OFS_ADDR_LOW)) begin
        nvm_address[7:0] <= io_wdata;
      end
      if (hit(eac_pkg::EAC_OFS_ADDR_HIGH)) begin
        nvm_address[8] <= io_wdata[0] & eac_pkg::EAC_HAS_TOP_BIT;
      end
    end
  end

  // A read result arriving during reset is dropped with the clear
  always_ff @(posedge clk) begin
    if (!resetn) begin
      nvm_data <= eac_pkg::EAC_DATA_RESET;
    end else if (read_pending) begin
      nvm_data <= mem_rdata;
    end else if (hit(eac_pkg::EAC_OFS_DATA)) begin
      nvm_data <= io_wdata;
    end
  end

  // *****************************************************************************
  // Array interface
  // *****************************************************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mem_read     <= 1'b0;
      read_pending <= 1'b0;
    end else begin
      mem_read     <= start_read;
      read_pending <= mem_read;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn && !busy) begin
      mem_addr  <= 9'h000;
      mem_wdata <= 8'h00;
    end else if (!busy) begin
      mem_addr  <= {nvm_address[8] & eac_pkg::EAC_HAS_TOP_BIT, nvm_address[7:0]};
      mem_wdata <= nvm_data;
    end
  end

  // *****************************************************************************
  // CPU stall
  // *****************************************************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      stall_count <= 3'h0;
      cpu_stall   <= 1'b0;
    end else if (start_prog) begin
      stall_count <= eac_pkg::EAC_PROG_STALL - 3'h1;
      cpu_stall   <= 1'b1;
    end else if (start_read) begin
      stall_count <= eac_pkg::EAC_READ_STALL - 3'h1;
      cpu_stall   <= 1'b1;
    end else if (stall_count != 3'h0) begin
      stall_count <= stall_count - 3'h1;
      cpu_stall   <= 1'b1;
    end else begin
      cpu_stall   <= 1'b0;
    end
  end

  // *****************************************************************************
  // Ready interrupt
  // *****************************************************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ready_irq <= 1'b0;
    end else begin
      ready_irq <= ready_irq_enable && global_irq_enable && !prog_enable;
    end
  end

  // *****************************************************************************
  // Read port
  // *****************************************************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      io_rdata <= 8'h00;
    end else if (io_read) begin
      case (io_addr)
        eac_pkg::EAC_OFS_CONTROL: begin
          io_rdata <= {2'h0, prog_mode_field, ready_irq_enable,
                       master_prog_enable, prog_enable, 1'b0};
        end
        eac_pkg::EAC_OFS_DATA: begin
          io_rdata <= nvm_data;
        end
        eac_pkg::EAC_OFS_ADDR_LOW: begin
          io_rdata <= nvm_address[7:0];
        end
        eac_pkg::EAC_OFS_ADDR_HIGH: begin
          io_rdata <= {7'h00, nvm_address[8] & eac_pkg::EAC_HAS_TOP_BIT};
        end
        default: begin
          io_rdata <= 8'h00;
        end
      endcase
    end
  end

endmodule : eac_core
`default_nettype wire

// >>> test/eac_core_props.sv
// Concurrent checks on the ports of the nonvolatile memory access control block
`timescale 1ns/100ps
`default_nettype none
module eac_core_props #(
  parameter int ATOMIC_TICKS = 20,
  parameter int SPLIT_TICKS  = 10
) (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic [5:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic       io_write,
  input wire logic       io_read,
  input wire logic [7:0] io_rdata,
  input wire logic       global_irq_enable,
  input wire logic       osc_clk,
  input wire logic [8:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic       mem_read,
  input wire logic       mem_erase,
  input wire logic       mem_program,
  input wire logic [7:0] mem_rdata,
  input wire logic       cpu_stall,
  input wire logic       ready_irq
);
  wire busy = mem_erase | mem_program;
  default clocking cb_main @(posedge clk); endclocking
  default disable iff (!resetn);
  // ****
  // Port relations
  // ****
  a_read_stall: assert property (mem_read |-> cpu_stall [*4] ##1 !cpu_stall)
    else $error("read stall length wrong");
  a_read_pulse: assert property (mem_read |=> !mem_read)
    else $error("array read strobe too long");
  a_busy_no_read: assert property (busy |-> !mem_read)
    else $error("array read during programming");
  a_addr_frozen: assert property (busy && $past(busy) |-> $stable(mem_addr))
    else $error("address moved during programming");
  a_op_stable: assert property (busy && $past(busy) |-> $stable({mem_erase, mem_program, mem_wdata}))
    else $error("operation changed during programming");
  a_prog_stall: assert property ($rose(busy) |-> cpu_stall [*2] ##1 !cpu_stall)
    else $error("program stall length wrong");
  a_irq_busy: assert property (busy |=> !ready_irq)
    else $error("ready interrupt while busy");
  a_irq_gie: assert property (!global_irq_enable |=> !ready_irq)
    else $error("ready interrupt without global enable");
endmodule : eac_core_props

bind eac_core eac_core_props #(.ATOMIC_TICKS(ATOMIC_TICKS), .SPLIT_TICKS(SPLIT_TICKS))
  eac_core_props_inst (.clk(clk), .resetn(resetn), .io_addr(io_addr), .io_wdata(io_wdata),
  .io_write(io_write), .io_read(io_read), .io_rdata(io_rdata), .osc_clk(osc_clk),
  .global_irq_enable(global_irq_enable), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
  .mem_read(mem_read), .mem_erase(mem_erase), .mem_program(mem_program),
  .mem_rdata(mem_rdata), .cpu_stall(cpu_stall), .ready_irq(ready_irq));
`default_nettype wire

// >>> test/tb_eac_core.sv
// Self-checking bench for the nonvolatile memory access control block
`timescale 1ns/100ps
`default_nettype none
module tb_eac_core;
  localparam logic [5:0] CTL = eac_pkg::EAC_OFS_CONTROL;
  localparam logic [5:0] DAT = eac_pkg::EAC_OFS_DATA;
  localparam logic [5:0] AL  = eac_pkg::EAC_OFS_ADDR_LOW;
  localparam logic [5:0] AH  = eac_pkg::EAC_OFS_ADDR_HIGH;
  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  logic [5:0] io_addr = 6'h00;
  logic [7:0] io_wdata = 8'h00;
  logic       io_write = 1'b0;
  logic       io_read = 1'b0;
  logic [7:0] io_rdata;
  logic       global_irq_enable = 1'b1;
  logic       osc_clk = 1'b0;
  logic [8:0] mem_addr;
  logic [7:0] mem_wdata;
  logic       mem_read;
  logic       mem_erase;
  logic       mem_program;
  logic [7:0] mem_rdata = 8'h00;
  logic       cpu_stall;
  logic       ready_irq;
  int         failures = 0;
  int         num_checks = 0;
  int         busy_len = 0;
  int         reads = 0;

  always #2 clk = ~clk;
  always #20 osc_clk = ~osc_clk;
  // Array contents are a fixed function of the address
  always @(negedge clk) mem_rdata <= mem_addr[7:0] ^ 8'h5A;
  always @(posedge clk) begin
    busy_len <= busy_len + int'(mem_erase | mem_program);
    reads <= reads + int'(mem_read);
  end

  eac_core #(.ATOMIC_TICKS(20), .SPLIT_TICKS(10)) eac_core_inst (
    .clk(clk), .resetn(resetn), .io_addr(io_addr), .io_wdata(io_wdata), .io_write(io_write),
    .io_read(io_read), .io_rdata(io_rdata), .global_irq_enable(global_irq_enable),
    .osc_clk(osc_clk), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_read(mem_read),
    .mem_erase(mem_erase), .mem_program(mem_program), .mem_rdata(mem_rdata),
    .cpu_stall(cpu_stall), .ready_irq(ready_irq));

  // ****
  // Bus cycles and comparisons
  // ****
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    io_addr = a;
    io_wdata = d;
    io_write = 1'b1;
    @(negedge clk);
    io_write = 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    @(negedge clk);
    io_addr = a;
    io_read = 1'b1;
    @(negedge clk);
    io_read = 1'b0;
    @(negedge clk);
    chk({1'b0, io_rdata}, {1'b0, exp});
  endtask : rd

  task automatic stall_chk(input int exp);
    int n;
    n = 0;
    // The caller returns on the falling edge right after the strobe edge,
    // so the first stalled cycle is already showing and must be counted
    repeat (8) begin
      if (cpu_stall === 1'b1) n++;
      @(negedge clk);
    end
    chk(9'(n), 9'(exp));
  endtask : stall_chk

  task automatic wait_idle;
    int n;
    n = 0;
    while ((mem_erase | mem_program) !== 1'b0 && n < 400) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_idle

  // ****
  // Scenarios
  // ****
  task automatic t_regs;
    rd(CTL, 8'h00);
    rd(DAT, 8'h00);
    wr(CTL, 8'hC8);
    rd(CTL, 8'h08);
    wr(AL, 8'hA7);
    wr(AH, 8'h01);
    rd(AH, 8'h00);
    rd(AL, 8'hA7);
    chk(mem_addr, 9'h0A7);
  endtask : t_regs

  task automatic t_irq;
    global_irq_enable = 1'b0;
    repeat (2) @(negedge clk);
    chk(9'(ready_irq), 9'h000);
    global_irq_enable = 1'b1;
    repeat (2) @(negedge clk);
    chk(9'(ready_irq), 9'h001);
    wr(CTL, 8'h00);
    repeat (2) @(negedge clk);
    chk(9'(ready_irq), 9'h000);
  endtask : t_irq

  task automatic t_read;
    wr(CTL, 8'h01);
    stall_chk(4);
    rd(DAT, 8'hFD);
  endtask : t_read

  task automatic t_refuse;
    wr(CTL, 8'h02);
    stall_chk(0);
    rd(CTL, 8'h00);
    wr(CTL, 8'h04);
    rd(CTL, 8'h04);
    @(negedge clk);
    rd(CTL, 8'h00);
    wr(CTL, 8'h04);
    repeat (3) @(negedge clk);
    wr(CTL, 8'h02);
    stall_chk(0);
  endtask : t_refuse

  task automatic t_prog(input logic [1:0] m, input int ticks);
    logic [7:0] c;
    int         r;
    c = {2'b00, m, 4'h8};
    wr(DAT, 8'h3C);
    wr(CTL, c | 8'h04);
    repeat (2) @(negedge clk);
    busy_len = 0;
    wr(CTL, c | 8'h06);
    stall_chk(m == 2'h3 ? 0 : 2);
    chk(9'({mem_erase, mem_program}), 9'({~m[1], ~m[0]}));
    if (m != 2'h3) begin
      r = reads;
      chk(9'(ready_irq), 9'h000);
      chk(9'(mem_wdata), 9'h03C);
      rd(CTL, c | 8'h02);
      wr(CTL, {2'b00, ~m, 4'hA});
      wr(AL, 8'h11);
      wr(CTL, c | 8'h03);
      wait_idle;
      chk(9'(reads), 9'(r));
      chk(9'(busy_len >= ticks * 10 - 10 && busy_len <= ticks * 10 + 15), 9'h001);
      repeat (2) @(negedge clk);
      chk(9'(ready_irq), 9'h001);
      rd(CTL, c);
      chk(mem_addr, 9'h0A7);
    end
  endtask : t_prog

  task automatic t_rst;
    wr(CTL, 8'h1C);
    repeat (2) @(negedge clk);
    busy_len = 0;
    wr(CTL, 8'h1E);
    repeat (3) @(negedge clk);
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    chk(9'({mem_erase, mem_program, ready_irq}), 9'h004);
    wait_idle;
    chk(9'(busy_len >= 90 && busy_len <= 115), 9'h001);
    rd(CTL, 8'h10);
    resetn = 1'b0;
    @(negedge clk);
    resetn = 1'b1;
    rd(CTL, 8'h00);
  endtask : t_rst

  task automatic give_verdict;
    if (failures == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    t_regs;
    t_irq;
    t_read;
    t_refuse;
    t_prog(eac_pkg::EAC_MODE_ATOMIC, 20);
    t_prog(eac_pkg::EAC_MODE_ERASE, 10);
    t_prog(eac_pkg::EAC_MODE_WRITE, 10);
    t_prog(eac_pkg::EAC_MODE_RESERVED, 0);
    t_rst;
    give_verdict;
  end

  initial begin
    #100000;
    failures++;
    give_verdict;
  end
endmodule : tb_eac_core
`default_nettype wire
